//--- hw/delay_counter.sv
// Down counter that reports when a loaded delay has run out.
`timescale 1ns/10ps
module delay_counter #(
    parameter int WIDTH = 24
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             load_i,
    input  wire logic [WIDTH-1:0] count_i,
    output logic                  done_o
);
    logic [WIDTH-1:0] count_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_reg <= '0;
        end else if (load_i) begin
            count_reg <= count_i;
        end else if (count_reg != '0) begin
            count_reg <= count_reg - 1'b1;
        end
    end

    assign done_o = (count_reg == '0) && !load_i;
endmodule

//--- hw/sensor_measure_sequencer.sv
// Sequencer that powers the transducer chain, times settling and triggers the converter.
//
// Implementation choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/10ps
module sensor_measure_sequencer #(
    parameter int CONV_PERIOD = measure_pkg::CONV_PERIOD_CYC,
    parameter int SETTLE_UNIT = measure_pkg::SETTLE_UNIT_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    input  wire logic        we_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    output logic             ack_o,
    input  wire logic        deep_stop_mode_i,
    input  wire logic        run_mode_i,
    input  wire logic        conversion_complete_i,
    input  wire logic [7:0]  conversion_result_i,
    output logic             front_end_on_o,
    output logic             converter_trigger_o,
    output logic             conversion_complete_clear_o,
    output logic             standby_o
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic deep_meta_reg, deep_reg, run_meta_reg, run_reg, done_meta_reg, done_reg, done_old_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            deep_meta_reg <= 1'b0;
            deep_reg      <= 1'b0;
            run_meta_reg  <= 1'b0;
            run_reg       <= 1'b0;
            done_meta_reg <= 1'b0;
            done_reg      <= 1'b0;
            done_old_reg  <= 1'b0;
        end else begin
            deep_meta_reg <= deep_stop_mode_i;
            deep_reg      <= deep_meta_reg;
            run_meta_reg  <= run_mode_i;
            run_reg       <= run_meta_reg;
            done_meta_reg <= conversion_complete_i;
            done_reg      <= done_meta_reg;
            done_old_reg  <= done_reg;
        end
    end

    wire conv_done = done_reg && !done_old_reg;

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    logic ack_reg;
    wire  req      = cyc_i && stb_i && !ack_reg;
    wire  wr       = req && we_i && sel_i[0];
    wire  wr_stat  = wr && adr_i == measure_pkg::STATUS_CONTROL_ADDR;
    wire  wr_ctrl  = wr && adr_i == measure_pkg::CONTROL_ADDR;
    wire  wr_set   = wr && adr_i == measure_pkg::SETTLE_ADDR;
    wire  rd_low   = req && !we_i && adr_i == measure_pkg::RESULT_LOW_ADDR;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req;
        end
    end

    assign ack_o = ack_reg;

    // ------------------------------------------------------------
    // Control bits
    // ------------------------------------------------------------
    logic       auto_start_reg, low_power_direct_bit_reg, irq_en_reg, measure_irq_flag_reg;
    logic       chain_enable_reg, capture_trigger_reg, clear_sync_reg;
    logic [2:0] settle_select_reg;
    logic [7:0] init_delay_reg, sub_period_reg;
    measure_pkg::seq_state_t state_reg;
    logic       first_reg, conv_busy_reg;
    logic [1:0] sync_cnt_reg;
    logic       settle_load, conv_load, settle_done, conv_period_done;

    wire auto_mode   = auto_start_reg;
    wire lp_mode     = low_power_direct_bit_reg && chain_enable_reg;
    wire auto_done   = auto_mode && state_reg == measure_pkg::ST_FINISH && conv_done;
    wire fe_low      = !front_end_on_o;

    always_ff @(posedge clk_i) begin
        if (rst_i || deep_reg) begin
            auto_start_reg <= 1'b0; // R02
        end else if (auto_done
                     || (auto_start_reg && fe_low && state_reg != measure_pkg::ST_IDLE)) begin
            auto_start_reg <= 1'b0; // R05 R06
        end else if (wr_stat && dat_i[measure_pkg::AUTO_START_BIT] && !clear_sync_reg
                     && !chain_enable_reg) begin
            auto_start_reg <= 1'b1; // R03
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clear_sync_reg <= 1'b0;
            sync_cnt_reg   <= '0;
        end else if (auto_done) begin
            clear_sync_reg <= 1'b1; // R06
            sync_cnt_reg   <= 2'(measure_pkg::SYNC_CLEAR_CYC);
        end else if (sync_cnt_reg != '0) begin
            sync_cnt_reg <= sync_cnt_reg - 2'd1;
        end else begin
            clear_sync_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            low_power_direct_bit_reg <= 1'b0;
            irq_en_reg               <= 1'b0;
        end else if (wr_stat) begin
            low_power_direct_bit_reg <= dat_i[measure_pkg::LOW_POWER_BIT];
            irq_en_reg               <= dat_i[measure_pkg::IRQ_EN_BIT];
        end
    end

    // The flag only reports in run mode in plain direct mode; set wins over acknowledge.
    wire irq_event = state_reg == measure_pkg::ST_SETTLE && settle_done && irq_en_reg
                     && run_reg && !auto_mode && !low_power_direct_bit_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            measure_irq_flag_reg <= 1'b0;
        end else if (irq_event) begin
            measure_irq_flag_reg <= 1'b1; // R08
        end else if (wr_stat && dat_i[measure_pkg::IRQ_ACK_BIT]) begin
            measure_irq_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || deep_reg) begin
            chain_enable_reg <= 1'b0; // R02
        end else if (wr_ctrl && !auto_mode) begin
            if (dat_i[measure_pkg::CHAIN_EN_BIT]) begin
                chain_enable_reg <= 1'b1;
            end else if (!capture_trigger_reg) begin
                chain_enable_reg <= 1'b0; // R14 R15
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || deep_reg) begin
            capture_trigger_reg <= 1'b0;
        end else if (wr_ctrl && dat_i[measure_pkg::CAPTURE_BIT] && chain_enable_reg) begin
            capture_trigger_reg <= 1'b1; // R13
        end else if (!low_power_direct_bit_reg) begin
            capture_trigger_reg <= 1'b0; // R12 R24
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            settle_select_reg <= '0;
            init_delay_reg    <= '0;
            sub_period_reg    <= '0;
        end else if (wr_set) begin
            settle_select_reg <= dat_i[measure_pkg::SETTLE_MSB:measure_pkg::SETTLE_LSB];
            init_delay_reg    <= dat_i[15:8];
            sub_period_reg    <= dat_i[23:16];
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    logic [23:0] settle_count;

    // Selection zero gives the shortest delay, sampling before the signal is steady.
    always_comb begin
        if (state_reg == measure_pkg::ST_IDLE && auto_mode) begin
            settle_count = 24'((settle_select_reg + 3'd1) * SETTLE_UNIT); // R21
        end else if (lp_mode && first_reg && state_reg == measure_pkg::ST_IDLE) begin
            settle_count = 24'((init_delay_reg + 8'd1) * SETTLE_UNIT); // R25
        end else if (lp_mode) begin
            settle_count = 24'((sub_period_reg + 8'd1) * SETTLE_UNIT); // R17
        end else begin
            settle_count = 24'(measure_pkg::CAPTURE_DELAY_CYC); // R11
        end
    end

    wire start_auto = state_reg == measure_pkg::ST_IDLE && auto_mode;
    wire start_dir  = state_reg == measure_pkg::ST_IDLE && capture_trigger_reg && !deep_reg;
    // The next settle starts at the trigger, so it overlaps the conversion period.
    wire lp_next    = lp_mode && state_reg == measure_pkg::ST_TRIGGER; // R19
    wire fire       = state_reg == measure_pkg::ST_SETTLE && settle_done && !deep_reg
                      && (auto_mode || chain_enable_reg);
    assign settle_load = start_auto || start_dir || lp_next;
    assign conv_load   = state_reg == measure_pkg::ST_TRIGGER;

    delay_counter #(.WIDTH(24)) settle_timer (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .load_i (settle_load),
        .count_i(settle_count),
        .done_o (settle_done)
    );

    delay_counter #(.WIDTH(24)) conv_timer (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .load_i (conv_load),
        .count_i(24'(CONV_PERIOD)), // R18
        .done_o (conv_period_done)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i || deep_reg) begin
            state_reg <= measure_pkg::ST_IDLE; // R02
        end else begin
            case (state_reg)
                measure_pkg::ST_IDLE: begin
                    if (settle_load) begin
                        state_reg <= measure_pkg::ST_SETTLE;
                    end
                end
                measure_pkg::ST_SETTLE: begin
                    if (!auto_mode && !chain_enable_reg) begin
                        state_reg <= measure_pkg::ST_IDLE; // R15
                    end else if (settle_done) begin
                        state_reg <= measure_pkg::ST_TRIGGER; // R04 R11
                    end
                end
                measure_pkg::ST_TRIGGER: begin
                    state_reg <= auto_mode ? measure_pkg::ST_FINISH : measure_pkg::ST_CONVERT;
                end
                measure_pkg::ST_CONVERT: begin
                    if (!lp_mode) begin
                        state_reg <= measure_pkg::ST_IDLE; // R15
                    end else if (conv_period_done) begin
                        state_reg <= measure_pkg::ST_SETTLE; // R19
                    end
                end
                measure_pkg::ST_FINISH: begin
                    if (!auto_mode) begin
                        state_reg <= measure_pkg::ST_IDLE; // R09
                    end
                end
                default: state_reg <= measure_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || !lp_mode) begin
            first_reg <= 1'b1; // R25
        end else if (state_reg == measure_pkg::ST_TRIGGER) begin
            first_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            converter_trigger_o <= 1'b0;
        end else begin
            converter_trigger_o <= fire; // R26 R02
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            front_end_on_o              <= 1'b0;
            conversion_complete_clear_o <= 1'b0;
            standby_o                   <= 1'b1;
        end else begin
            front_end_on_o              <= (auto_mode || chain_enable_reg) && !deep_reg;
            conversion_complete_clear_o <= rd_low; // R22
            standby_o <= !chain_enable_reg && !measure_irq_flag_reg && !auto_start_reg
                         && !capture_trigger_reg && settle_select_reg == '0; // R01
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [31:0] rd_next;

    always_comb begin
        rd_next = '0;
        case (adr_i)
            measure_pkg::STATUS_CONTROL_ADDR: rd_next[7:0] = {measure_irq_flag_reg && !auto_mode,
                1'b0, irq_en_reg, auto_start_reg, low_power_direct_bit_reg, 3'b000}; // R08
            measure_pkg::CONTROL_ADDR: rd_next[7:0] = {chain_enable_reg, capture_trigger_reg, 6'h00};
            measure_pkg::SETTLE_ADDR: rd_next[23:0] = {sub_period_reg, init_delay_reg,
                5'h00, settle_select_reg};
            measure_pkg::RESULT_LOW_ADDR: rd_next[7:0] = conversion_result_i;
            measure_pkg::STATE_ADDR: rd_next[7:0] = {3'b000, clear_sync_reg, first_reg, state_reg};
            default: rd_next = '0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= '0;
        end else if (req && !we_i) begin
            dat_o <= rd_next;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_trigger_pulse: assert property (@(posedge clk_i) disable iff (rst_i) // R26
        converter_trigger_o |=> !converter_trigger_o) else $error("trigger longer than one cycle");
    a_deep_stop_idle: assert property (@(posedge clk_i) disable iff (rst_i) // R02
        deep_reg |=> !converter_trigger_o && state_reg == measure_pkg::ST_IDLE)
        else $error("measurement during deep stop");
    a_capture_clear: assert property (@(posedge clk_i) disable iff (rst_i) // R12
        capture_trigger_reg && !low_power_direct_bit_reg && !wr_ctrl |=> !capture_trigger_reg)
        else $error("capture trigger not cleared");
    a_chain_hold: assert property (@(posedge clk_i) disable iff (rst_i) // R14
        chain_enable_reg && capture_trigger_reg && !deep_reg |=> chain_enable_reg)
        else $error("chain disabled while capture set");
    sequence s_start_drop;
        !auto_start_reg ##1 !front_end_on_o;
    endsequence
    a_auto_clear: assert property (@(posedge clk_i) disable iff (rst_i) // R05
        auto_done |=> s_start_drop) else $error("auto start not cleared");
    a_irq_auto: assert property (@(posedge clk_i) disable iff (rst_i) // R08
        auto_mode && !measure_irq_flag_reg |=> !measure_irq_flag_reg)
        else $error("irq flag set in automatic mode");
    a_result_clear: assert property (@(posedge clk_i) disable iff (rst_i) // R22
        rd_low |=> conversion_complete_clear_o) else $error("complete not cleared on read");
    a_first_delay: assert property (@(posedge clk_i) disable iff (rst_i) // R25
        $rose(lp_mode) |=> first_reg) else $error("low power entry without initial delay");
endmodule

//--- pkg/measure_pkg.sv
// Constants and register layout for the sensor measurement sequencer.
// How it works
// R01 - All control bits zero means standby
// R02 - Deep stop disables every measurement
// R03 - Writing auto start bit 4 starts one
// R04 - Automatic trigger fires after sample delay
// R05 - Auto start self clears, front end off
// R06 - Start clear sync gates next auto start
// R07 - Software polls, waits before restarting auto
// R08 - Irq flag unavailable in automatic mode
// R09 - Mode availability versus processor run state
// R10 - Software selects channel, enables, waits, captures
// R11 - Direct capture triggers after capture delay
// R12 - Capture trigger clears after one cycle; the code holds it while the low power bit is set
// R13 - Repeat captures while chain enabled
// R14 - Chain disable ignored while capture set
// R15 - Chain disable returns block to standby
// R16 - Software resettles after channel change
// R17 - Low power results: initial then periodic
// R18 - Conversion period covers convert, wake, finish
// R19 - Conversion runs alongside next settle period
// R20 - Firmware reads result before next period
// R21 - Short settle selections sample early
// R22 - Reading result low byte clears complete
// R23 - Enter low power: bit, enable, capture
// R24 - Leaving low power clears capture automatically
// R25 - New entry uses initial delay first
// R26 - Converter trigger is one clock pulse
package measure_pkg;
    // ------------------------------------------------------------
    // Register map, byte addresses on a 32-bit Wishbone bus
    // ------------------------------------------------------------
    localparam logic [7:0] STATUS_CONTROL_ADDR = 8'h40;
    localparam logic [7:0] CONTROL_ADDR        = 8'h44;
    localparam logic [7:0] SETTLE_ADDR         = 8'h48;
    localparam logic [7:0] RESULT_LOW_ADDR     = 8'h4c;
    localparam logic [7:0] STATE_ADDR          = 8'h50;

    localparam int IRQ_FLAG_BIT   = 7;
    localparam int IRQ_ACK_BIT    = 6;
    localparam int IRQ_EN_BIT     = 5;
    localparam int AUTO_START_BIT = 4;
    localparam int LOW_POWER_BIT  = 3;
    localparam int CHAIN_EN_BIT   = 7;
    localparam int CAPTURE_BIT    = 6;
    localparam int SETTLE_LSB     = 0;
    localparam int SETTLE_MSB     = 2;

    localparam logic [7:0] STATUS_RESET  = 8'h00;
    localparam logic [7:0] CONTROL_RESET = 8'h00;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ          = 100;
    localparam int CONVERT_US       = 15;
    localparam int WAKE_US          = 4;
    localparam int FINISH_TASK_US   = 33;
    localparam int CONV_PERIOD_CYC  = (CONVERT_US + WAKE_US + FINISH_TASK_US) * CLK_MHZ;
    localparam int CAPTURE_DELAY_CYC = 4;
    localparam int SYNC_CLEAR_CYC    = 2;
    localparam int SETTLE_UNIT_CYC   = 1000;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_SETTLE  = 3'b001,
        ST_TRIGGER = 3'b011,
        ST_CONVERT = 3'b010,
        ST_FINISH  = 3'b110
    } seq_state_t;
endpackage

//--- tb/converter_model.sv
// Behavioural converter that answers each trigger with a result and a complete flag.
`timescale 1ns/10ps
module converter_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       trigger_i,
    input  wire logic       clear_i,
    input  wire logic       slow_i,
    input  wire logic [7:0] value_i,
    output logic            complete_o,
    output logic [7:0]      result_o
);
    int left;

    // A slow answer still ends inside one conversion period, so periodic runs never overlap.
    always @(posedge clk_i) begin
        if (rst_i) begin
            left <= 0;
            complete_o <= 1'b0;
            result_o <= 8'h00;
        end else begin
            if (left > 0) begin
                left <= left - 1;
            end
            if (trigger_i === 1'b1) begin
                left <= slow_i ? 12 : 3;
                complete_o <= 1'b0;
            end else if (left == 1) begin
                complete_o <= 1'b1;
                result_o <= value_i;
            end else if (clear_i === 1'b1) begin
                complete_o <= 1'b0;
            end
        end
    end
endmodule

//--- tb/sensor_measure_sequencer_tb_top.sv
// Self-checking testbench for the sensor measurement sequencer.
`timescale 1ns/10ps
module sensor_measure_sequencer_tb_top;
    localparam int CP = 20;
    localparam int SU = 5;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat_w = 32'h0;
    logic        we = 1'b0;
    logic [3:0]  sel = 4'h0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        deep_stop = 1'b0;
    logic        run_mode = 1'b1;
    logic        slow = 1'b0;
    logic [7:0]  next_val = 8'h5a;
    logic [31:0] seed = 32'd82296;
    logic [31:0] rd;
    logic [31:0] dat_o;
    logic        ack_o;
    logic        fe_on;
    logic        trig;
    logic        cc;
    logic        cc_clr;
    logic        standby;
    logic [7:0]  res;
    logic        trig_prev = 1'b0;
    int          err_total = 0;
    int          n_compared = 0;
    int          cyc_n = 0;
    int          trig_n = 0;
    int          trig_at = 0;
    int          last_ack = 0;

    sensor_measure_sequencer #(.CONV_PERIOD(CP), .SETTLE_UNIT(SU)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(dat_w), .dat_o(dat_o),
        .we_i(we), .sel_i(sel), .cyc_i(cyc), .stb_i(stb), .ack_o(ack_o),
        .deep_stop_mode_i(deep_stop), .run_mode_i(run_mode),
        .conversion_complete_i(cc), .conversion_result_i(res),
        .front_end_on_o(fe_on), .converter_trigger_o(trig),
        .conversion_complete_clear_o(cc_clr), .standby_o(standby));

    converter_model adc (
        .clk_i(clk_i), .rst_i(rst_i), .trigger_i(trig), .clear_i(cc_clr),
        .slow_i(slow), .value_i(next_val), .complete_o(cc), .result_o(res));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    function automatic int exp_first(input int v);
        return (v + 1) * SU;
    endfunction

    // Periodic spacing is the subsequent period, never shorter than one conversion period.
    function automatic int exp_next(input int p);
        return ((p + 1) * SU > CP) ? (p + 1) * SU : CP;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Settle timing tolerates a few cycles of synchroniser and state-machine slack.
    task automatic near(input int got, input int e, input int tol);
        chk(((got >= e - tol) && (got <= e + tol)) ? e : got, e);
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        adr <= a;
        dat_w <= d;
        we <= w;
        sel <= 4'hf;
        cyc <= 1'b1;
        stb <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 50);
        chk(ack_o, 1);
        rd = dat_o;
        last_ack = cyc_n;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wait_trig(input int s);
        int k;
        k = 0;
        while (trig_n == s && k < 2000) begin
            @(posedge clk_i);
            k++;
        end
        @(posedge clk_i);
        chk(trig_n - s, 1);
    endtask

    task automatic get_result;
        int k;
        k = 0;
        while (cc !== 1'b1 && k < 100) begin
            @(posedge clk_i);
            k++;
        end
        wb(1'b0, 8'h4c, 32'h0);
        chk(rd, {24'h0, next_val});
        repeat (4) @(posedge clk_i);
        chk(cc, 0);
        seed = xs(seed);
        next_val <= seed[7:0];
        slow <= seed[8];
    endtask

    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        trig_prev <= trig;
        if (trig === 1'b1) begin
            trig_n <= trig_n + 1;
            trig_at <= cyc_n;
            if (trig_prev === 1'b1) chk(2, 1);
        end
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_direct;
        int s;
        wb(1'b1, 8'h40, 32'h20);
        wb(1'b1, 8'h44, 32'h80);
        repeat (2) @(posedge clk_i);
        chk(fe_on, 1);
        chk(standby, 0);
        for (int k = 0; k < 3; k++) begin
            repeat (SU) @(posedge clk_i);
            s = trig_n;
            wb(1'b1, 8'h44, 32'hc0);
            wait_trig(s);
            near(trig_at - last_ack, measure_pkg::CAPTURE_DELAY_CYC, 3);
            wb(1'b0, 8'h44, 32'h0);
            chk(rd, 32'h80);
            get_result();
        end
        wb(1'b0, 8'h40, 32'h0);
        chk(rd, 32'ha0);
        wb(1'b1, 8'h40, 32'h40);
        wb(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h00);
        wb(1'b1, 8'h44, 32'h0);
        repeat (3) @(posedge clk_i);
        chk(standby, 1);
        chk(fe_on, 0);
        $display("direct mode test done");
    endtask

    task automatic t_auto(input int s);
        int st;
        int a;
        int k;
        seed = xs(seed);
        run_mode <= seed[0];
        wb(1'b1, 8'h48, s);
        st = trig_n;
        wb(1'b1, 8'h40, 32'h30);
        a = last_ack;
        wb(1'b0, 8'h40, 32'h0);
        chk(rd[4], 1);
        wait_trig(st);
        near(trig_at - a, exp_first(s), 8);
        k = 0;
        do begin
            wb(1'b0, 8'h40, 32'h0);
            k++;
        end while (rd[4] !== 1'b0 && k < 60);
        chk(rd[4], 0);
        chk(rd[7], 0);
        chk(fe_on, 0);
        get_result();
        repeat (8) @(posedge clk_i);
        run_mode <= 1'b1;
        $display("auto mode test done");
    endtask

    task automatic t_lpd(input int i, input int p);
        int st;
        int a;
        int prev;
        wb(1'b1, 8'h48, {8'h0, p[7:0], i[7:0], 8'h0});
        wb(1'b1, 8'h40, 32'h08);
        wb(1'b1, 8'h44, 32'h80);
        st = trig_n;
        wb(1'b1, 8'h44, 32'hc0);
        a = last_ack;
        wait_trig(st);
        near(trig_at - a, exp_first(i), 8);
        for (int k = 0; k < 3; k++) begin
            prev = trig_at;
            st = trig_n;
            get_result();
            wait_trig(st);
            near(trig_at - prev, exp_next(p), 4);
        end
        get_result();
        wb(1'b1, 8'h44, 32'h0);
        wb(1'b1, 8'h40, 32'h0);
        wb(1'b0, 8'h44, 32'h0);
        chk(rd[6], 0);
        wb(1'b1, 8'h44, 32'h0);
        repeat (3) @(posedge clk_i);
        chk(standby, 1);
        $display("low power direct test done");
    endtask

    task automatic t_deep;
        int st;
        deep_stop <= 1'b1;
        repeat (4) @(posedge clk_i);
        st = trig_n;
        wb(1'b1, 8'h44, 32'hc0);
        wb(1'b1, 8'h40, 32'h10);
        repeat (60) @(posedge clk_i);
        chk(trig_n - st, 0);
        chk(fe_on, 0);
        deep_stop <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk(standby, 1);
        $display("deep stop test done");
    endtask

    task automatic stop_test;
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk_i);
        err_total++;
        stop_test();
    end

    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk(standby, 1);
        wb(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0);
        wb(1'b1, 8'h5c, 32'hff);
        wb(1'b0, 8'h5c, 32'h0);
        chk(rd, 32'h0);
        $display("reset test done");
        t_direct();
        t_auto(0);
        t_auto(7);
        for (int k = 0; k < 2; k++) begin
            seed = xs(seed);
            t_auto(seed % 8);
        end
        t_lpd(0, 0);
        for (int k = 0; k < 2; k++) begin
            seed = xs(seed);
            t_lpd(seed[2:0], seed[6:4]);
        end
        t_deep();
        stop_test();
    end
endmodule
